// [core/rating_match.sv]
// registered match of a recovered rating against the four blocking masks
`timescale 1ns/1ns
module rating_match
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire rating_pkg::rating_t rating_i,
  input wire logic rating_valid_i,
  input wire rating_pkg::masks_t masks_i,
  output logic match_o
);
  import rating_pkg::*;

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic is_film(input logic [1:0] sys);
    is_film = (sys == SYS_FILM_A) || (sys == SYS_FILM_B);
  endfunction : is_film

  function automatic logic tv_top(input logic [2:0] code, input logic [7:0] m,
                                  input int b_pg, input int b_14, input int b_ma);
    case (code)
      TV_PG: tv_top = m[b_pg];
      TV_14: tv_top = m[b_14];
      TV_MA: tv_top = m[b_ma];
      default: tv_top = 1'b0;
    endcase
  endfunction : tv_top

  logic film_hit;
  logic base_hit;
  logic desc_hit;
  logic match_q;

  // -------------------------------------------------------------------
  // film rating decode
  // -------------------------------------------------------------------
  always_comb
  begin
    film_hit = 1'b0;
    if (is_film(rating_i.first.system))
    begin
      case (rating_i.first.film)
        FILM_G: film_hit = masks_i.film[FB_G];
        FILM_PG: film_hit = masks_i.film[FB_PG];
        FILM_PG13: film_hit = masks_i.film[FB_PG13];
        FILM_R: film_hit = masks_i.film[FB_R];
        FILM_NC17: film_hit = masks_i.film[FB_NC17];
        FILM_X: film_hit = masks_i.film[FB_X];
        FILM_NR: film_hit = masks_i.film[FB_NR];
        default: film_hit = 1'b0;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // tv base age decode, descriptors ignored here
  // -------------------------------------------------------------------
  always_comb
  begin
    base_hit = 1'b0;
    if (rating_i.first.system == SYS_TV)
    begin
      case (rating_i.second.tv)
        TV_Y: base_hit = masks_i.tv_base[TB_Y];
        TV_Y7: base_hit = masks_i.tv_base[TB_Y7];
        TV_G: base_hit = masks_i.tv_base[TB_G];
        TV_PG: base_hit = masks_i.tv_base[TB_PG];
        TV_14: base_hit = masks_i.tv_base[TB_14];
        TV_MA: base_hit = masks_i.tv_base[TB_MA];
        default: base_hit = 1'b0;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // tv descriptor combinations
  // -------------------------------------------------------------------
  always_comb
  begin
    desc_hit = 1'b0;
    if (rating_i.first.system == SYS_TV)
    begin
      if (rating_i.second.sexual)
        desc_hit = desc_hit | tv_top(rating_i.second.tv, masks_i.tv_sv,
                                     SV_PG_S, SV_14_S, SV_MA_S);
      if (rating_i.second.violence)
      begin
        if (rating_i.second.tv == TV_Y7)
          desc_hit = desc_hit | masks_i.tv_sv[SV_Y7_FV];
        desc_hit = desc_hit | tv_top(rating_i.second.tv, masks_i.tv_sv,
                                     SV_PG_V, SV_14_V, SV_MA_V);
      end
      if (rating_i.first.dialogue && (rating_i.second.tv != TV_MA))
        desc_hit = desc_hit | tv_top(rating_i.second.tv, masks_i.tv_dl,
                                     DL_PG_D, DL_14_D, DL_14_D);
      if (rating_i.second.language)
        desc_hit = desc_hit | tv_top(rating_i.second.tv, masks_i.tv_dl,
                                     DL_PG_L, DL_14_L, DL_MA_L);
    end
  end

  // -------------------------------------------------------------------
  // registered match
  // -------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      match_q <= 1'b0;
    else
      match_q <= rating_valid_i & (film_hit | base_hit | desc_hit);
  end

  assign match_o = match_q;

endmodule : rating_match

// [core/rating_pkg.sv]
// constants and types shared by the rating blocking compare logic
package rating_pkg;

  // -------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] ADDR_FILM_MASK = 8'h06;
  localparam logic [7:0] ADDR_TV_BASE_MASK = 8'h09;
  localparam logic [7:0] ADDR_TV_SV_MASK = 8'h0A;
  localparam logic [7:0] ADDR_TV_DL_MASK = 8'h0B;
  localparam logic [7:0] ADDR_STATUS1 = 8'h0C;
  localparam logic [7:0] ADDR_STATUS2 = 8'h0D;
  localparam logic [7:0] ADDR_BLOCK_CTRL = 8'h0E;

  // -------------------------------------------------------------------
  // writable bits and reset values
  // -------------------------------------------------------------------
  localparam logic [7:0] WMASK_FILM = 8'h7F;
  localparam logic [7:0] WMASK_TV_BASE = 8'h3F;
  localparam logic [7:0] WMASK_TV_SV = 8'hF7;
  localparam logic [7:0] WMASK_TV_DL = 8'h73;
  localparam logic [7:0] WMASK_BLOCK_CTRL = 8'hFF;
  localparam logic [7:0] RESET_MASK = 8'h00;
  localparam logic [7:0] RESET_BLOCK_CTRL = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam int BLOCK_EN_BIT = 7;
  localparam int STATUS_FLAG_BIT = 7;

  // -------------------------------------------------------------------
  // rating system codes (a1 a0)
  // -------------------------------------------------------------------
  localparam logic [1:0] SYS_FILM_A = 2'h0;
  localparam logic [1:0] SYS_TV = 2'h1;
  localparam logic [1:0] SYS_FILM_B = 2'h2;

  // -------------------------------------------------------------------
  // film rating codes (r2 r1 r0)
  // -------------------------------------------------------------------
  localparam logic [2:0] FILM_G = 3'h1;
  localparam logic [2:0] FILM_PG = 3'h2;
  localparam logic [2:0] FILM_PG13 = 3'h3;
  localparam logic [2:0] FILM_R = 3'h4;
  localparam logic [2:0] FILM_NC17 = 3'h5;
  localparam logic [2:0] FILM_X = 3'h6;
  localparam logic [2:0] FILM_NR = 3'h7;

  // -------------------------------------------------------------------
  // tv guideline codes (g2 g1 g0)
  // -------------------------------------------------------------------
  localparam logic [2:0] TV_Y = 3'h1;
  localparam logic [2:0] TV_Y7 = 3'h2;
  localparam logic [2:0] TV_G = 3'h3;
  localparam logic [2:0] TV_PG = 3'h4;
  localparam logic [2:0] TV_14 = 3'h5;
  localparam logic [2:0] TV_MA = 3'h6;

  // -------------------------------------------------------------------
  // mask bit positions
  // -------------------------------------------------------------------
  localparam int FB_G = 0;
  localparam int FB_PG = 1;
  localparam int FB_PG13 = 2;
  localparam int FB_R = 3;
  localparam int FB_NC17 = 4;
  localparam int FB_X = 5;
  localparam int FB_NR = 6;
  localparam int TB_Y = 0;
  localparam int TB_Y7 = 1;
  localparam int TB_G = 2;
  localparam int TB_PG = 3;
  localparam int TB_14 = 4;
  localparam int TB_MA = 5;
  localparam int SV_PG_S = 0;
  localparam int SV_14_S = 1;
  localparam int SV_MA_S = 2;
  localparam int SV_Y7_FV = 4;
  localparam int SV_PG_V = 5;
  localparam int SV_14_V = 6;
  localparam int SV_MA_V = 7;
  localparam int DL_PG_D = 0;
  localparam int DL_14_D = 1;
  localparam int DL_PG_L = 4;
  localparam int DL_14_L = 5;
  localparam int DL_MA_L = 6;

  // -------------------------------------------------------------------
  // recovered rating bytes, low seven bits of each
  // -------------------------------------------------------------------
  typedef struct packed {
    logic       one_a;
    logic       dialogue;
    logic [1:0] system;
    logic [2:0] film;
  } rating_first_t;

  typedef struct packed {
    logic       one_b;
    logic       violence;
    logic       sexual;
    logic       language;
    logic [2:0] tv;
  } rating_second_t;

  typedef struct packed {
    rating_first_t  first;
    rating_second_t second;
  } rating_t;

  typedef struct packed {
    logic [7:0] film;
    logic [7:0] tv_base;
    logic [7:0] tv_sv;
    logic [7:0] tv_dl;
  } masks_t;

endpackage : rating_pkg

// [core/rating_block_compare.sv]
// program rating blocking compare with its mask and status registers
`timescale 1ns/1ns
module rating_block_compare
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire rating_pkg::rating_t rating_i,
  input wire logic rating_valid_i,
  output logic block_o
);
  import rating_pkg::*;

  masks_t masks_q;
  logic [7:0] block_ctrl_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic block_q;
  logic match;

  // -------------------------------------------------------------------
  // masked write helper
  // -------------------------------------------------------------------
  function automatic logic [7:0] wr_field(input logic [7:0] data, input logic [7:0] keep);
    wr_field = data & keep;
  endfunction : wr_field

  // -------------------------------------------------------------------
  // mask registers, reserved bits held at zero
  // -------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      masks_q.film <= RESET_MASK;
      masks_q.tv_base <= RESET_MASK;
      masks_q.tv_sv <= RESET_MASK;
      masks_q.tv_dl <= RESET_MASK;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        ADDR_FILM_MASK: masks_q.film <= wr_field(reg_wdata_i, WMASK_FILM);
        ADDR_TV_BASE_MASK: masks_q.tv_base <= wr_field(reg_wdata_i, WMASK_TV_BASE);
        ADDR_TV_SV_MASK: masks_q.tv_sv <= wr_field(reg_wdata_i, WMASK_TV_SV);
        ADDR_TV_DL_MASK: masks_q.tv_dl <= wr_field(reg_wdata_i, WMASK_TV_DL);
        default: masks_q <= masks_q;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // blocking control register
  // -------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      block_ctrl_q <= RESET_BLOCK_CTRL;
    else if (reg_wr_i && (reg_addr_i == ADDR_BLOCK_CTRL))
      block_ctrl_q <= wr_field(reg_wdata_i, WMASK_BLOCK_CTRL);
  end

  // -------------------------------------------------------------------
  // rating compare
  // -------------------------------------------------------------------
  rating_match u_match
  (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .rating_i(rating_i),
    .rating_valid_i(rating_valid_i),
    .masks_i(masks_q),
    .match_o(match)
  );

  // -------------------------------------------------------------------
  // blocking output
  // -------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      block_q <= 1'b0;
    else
      block_q <= block_ctrl_q[BLOCK_EN_BIT] & match;
  end

  assign block_o = block_q;

  // -------------------------------------------------------------------
  // read path
  // -------------------------------------------------------------------
  always_comb
  begin
    case (reg_addr_i)
      ADDR_FILM_MASK: rdata_d = masks_q.film;
      ADDR_TV_BASE_MASK: rdata_d = masks_q.tv_base;
      ADDR_TV_SV_MASK: rdata_d = masks_q.tv_sv;
      ADDR_TV_DL_MASK: rdata_d = masks_q.tv_dl;
      ADDR_STATUS1: rdata_d = {block_q, rating_i.first};
      ADDR_STATUS2: rdata_d = {rating_valid_i, rating_i.second};
      ADDR_BLOCK_CTRL: rdata_d = block_ctrl_q;
      default: rdata_d = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_q <= READ_UNMAPPED;
    else if (reg_rd_i)
      rdata_q <= rdata_d;
  end

  assign reg_rdata_o = rdata_q;

endmodule : rating_block_compare

// [verif/rating_props.sv]
// assertions on the rating blocking compare ports
`timescale 1ns/1ns
module rating_props
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire rating_pkg::rating_t rating_i,
  input wire logic rating_valid_i,
  input wire logic block_o
);
  import rating_pkg::*;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  property p_no_valid;
    !rating_valid_i |-> ##2 !block_o;
  endproperty
  a_no_valid: assert property (p_no_valid) else $error("block without valid");
  property p_bad_sys;
    rating_i.first.system == 2'h3 |-> ##2 !block_o;
  endproperty
  a_bad_sys: assert property (p_bad_sys) else $error("block on bad system");
  property p_film_zero;
    rating_i.first.system != SYS_TV && rating_i.first.film == 3'h0 |-> ##2 !block_o;
  endproperty
  a_film_zero: assert property (p_film_zero) else $error("block on film code 0");
  property p_stat1;
    reg_rd_i && reg_addr_i == ADDR_STATUS1
      |=> reg_rdata_o == {$past(block_o), $past(rating_i.first)};
  endproperty
  a_stat1: assert property (p_stat1) else $error("status 1 wrong");
  property p_stat2;
    reg_rd_i && reg_addr_i == ADDR_STATUS2
      |=> reg_rdata_o == {$past(rating_valid_i), $past(rating_i.second)};
  endproperty
  a_stat2: assert property (p_stat2) else $error("status 2 wrong");
  property p_unmapped;
    reg_rd_i && !(reg_addr_i inside {8'h06, [8'h09:8'h0E]}) |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_disable;
    reg_wr_i && reg_addr_i == ADDR_BLOCK_CTRL && !reg_wdata_i[7]
      ##1 !(reg_wr_i && reg_addr_i == ADDR_BLOCK_CTRL) |=> !block_o;
  endproperty
  a_disable: assert property (p_disable) else $error("block while disabled");
  property p_film_rb;
    reg_wr_i && reg_addr_i == ADDR_FILM_MASK ##1 !reg_wr_i
      ##1 (reg_rd_i && !reg_wr_i && reg_addr_i == ADDR_FILM_MASK)
      |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h7F);
  endproperty
  a_film_rb: assert property (p_film_rb) else $error("film readback");
endmodule : rating_props
bind rating_block_compare rating_props u_props (.mclk_i, .rst_i, .reg_wr_i, .reg_rd_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .rating_i, .rating_valid_i, .block_o);

// [verif/host_model.sv]
// host processor model on the register port
`timescale 1ns/1ns
module host_model
(
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  import rating_pkg::*;
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  function automatic logic [7:0] keep(input logic [7:0] a);
    case (a)
      ADDR_FILM_MASK: return 8'h7F;
      ADDR_TV_BASE_MASK: return 8'h3F;
      ADDR_TV_SV_MASK: return 8'hF7;
      ADDR_TV_DL_MASK: return 8'h73;
      default: return 8'hFF;
    endcase
  endfunction : keep
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit raw = 1'b0);
    @(posedge mclk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= raw ? d : d & keep(a);
    @(posedge mclk_i);
    wr_o <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask : rd
endmodule : host_model

// [verif/rating_block_compare_tb_top.sv]
// self-checking testbench for the rating blocking compare
`timescale 1ns/1ns
module rating_block_compare_tb_top;
  import rating_pkg::*;
  logic mclk;
  logic rst;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  rating_t rat;
  logic vld;
  logic block;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int seed = 32'h8303;
  int rv;
  masks_t m;
  logic [7:0] s;
  logic [7:0] regs [5] = '{8'h06, 8'h09, 8'h0A, 8'h0B, 8'h0E};
  rating_block_compare dut (.mclk_i(mclk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .rating_i(rat),
    .rating_valid_i(vld), .block_o(block));
  host_model host (.mclk_i(mclk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr),
    .wdata_o(wdata));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic rating_t mk(logic [1:0] y, logic [2:0] f, logic [2:0] t, logic [3:0] g);
    return {1'b1, g[3], y, f, 1'b1, g[2], g[1], g[0], t};
  endfunction : mk
  // flags: dialogue, violence, sexual, language
  function automatic logic exp_blk(rating_t r, logic v, masks_t k, logic en);
    int t;
    logic h;
    t = r.second.tv;
    h = 1'b0;
    if (r.first.system inside {SYS_FILM_A, SYS_FILM_B} && r.first.film != 3'h0)
      h = k.film[r.first.film - 1];
    if (r.first.system == SYS_TV && t inside {[1:6]})
      h = k.tv_base[t - 1];
    if (r.first.system == SYS_TV && t == 2)
      h |= r.second.violence & k.tv_sv[4];
    if (r.first.system == SYS_TV && t inside {[4:6]})
      h |= (r.second.sexual & k.tv_sv[t - 4]) | (r.second.violence & k.tv_sv[t + 1])
        | (r.second.language & k.tv_dl[t]) | (r.first.dialogue & (t != 6) & k.tv_dl[t - 4]);
    return v & en & h;
  endfunction : exp_blk
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic setm(input masks_t k, input logic en);
    host.wr(ADDR_FILM_MASK, k.film);
    host.wr(ADDR_TV_BASE_MASK, k.tv_base);
    host.wr(ADDR_TV_SV_MASK, k.tv_sv);
    host.wr(ADDR_TV_DL_MASK, k.tv_dl);
    host.wr(ADDR_BLOCK_CTRL, {en, 7'h00});
  endtask : setm
  task automatic apply(input rating_t r, input logic v);
    @(posedge mclk);
    rat <= r;
    vld <= v;
  endtask : apply
  task automatic probe(input masks_t k, input logic en);
    logic x;
    repeat (3) @(posedge mclk);
    #1;
    x = exp_blk(rat, vld, k, en);
    chk(block === x, "block output");
    host.rd(ADDR_STATUS1, s);
    chk(s === {x, rat.first}, "status byte");
    host.rd(ADDR_STATUS2, s);
    chk(s === {vld, rat.second}, "second status byte");
  endtask : probe
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  initial
  begin
    rst = 1'b1;
    rat = '0;
    vld = 1'b0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    foreach (regs[i])
    begin
      host.rd(regs[i], s);
      chk(s === 8'h00, "reset value");
      host.wr(regs[i], 8'hFF, 1'b1);
      host.rd(regs[i], s);
      chk(s === host.keep(regs[i]), "reserved bits");
    end
    host.rd(8'h01, s);
    chk(s === 8'h00, "unmapped read");
    for (int c = 1; c < 8; c++)
    begin
      m = '0;
      m.film = 8'h01 << (c - 1);
      setm(m, 1'b1);
      apply(mk(c[0] ? SYS_FILM_A : SYS_FILM_B, c[2:0], 3'h0, 4'h0), 1'b1);
      probe(m, 1'b1);
      m.film = ~m.film;
      setm(m, 1'b1);
      probe(m, 1'b1);
    end
    for (int t = 1; t < 7; t++)
    begin
      m = '0;
      m.tv_base = 8'h01 << (t - 1);
      setm(m, 1'b1);
      apply(mk(SYS_TV, 3'h0, t[2:0], 4'hF), 1'b1);
      probe(m, 1'b1);
      m.tv_base = ~m.tv_base;
      setm(m, 1'b1);
      probe(m, 1'b1);
    end
    for (int t = 2; t < 7; t++)
    begin
      m = '0;
      m.tv_sv = 8'hF7;
      setm(m, 1'b1);
      apply(mk(SYS_TV, 3'h0, t[2:0], 4'h6), 1'b1);
      probe(m, 1'b1);
      m = '0;
      m.tv_dl = 8'h73;
      setm(m, 1'b1);
      apply(mk(SYS_TV, 3'h0, t[2:0], 4'h9), 1'b1);
      probe(m, 1'b1);
    end
    m = '1;
    setm(m, 1'b0);
    probe(m, 1'b0);
    repeat (150)
    begin
      m = $random(seed);
      rv = $random(seed);
      setm(m, rv[14]);
      apply(mk(rv[1:0], rv[4:2], rv[7:5], rv[11:8]), rv[13:12] != 2'h0);
      probe(m, rv[14]);
    end
    wrap_up();
  end
endmodule : rating_block_compare_tb_top
